/* File: design/battery_charge_sequencer.v */
// Charge state machine of a switch-mode lithium charger.
// Assumes comparator results arrive asynchronously from the analog core.
//
// Notes on behaviour
// - Low battery at start enters conditioning.
// - Conditioning timer expiry stops charge, flags fault.
// - Precharge fault gives detect current; replacement clears.
// - Cell select picks one or two cell target.
// - Voltage regulation ends at termination current.
// - Safety timer backs termination; expiry is fault.
// - Recharge, reset, enable toggle, timer pin restart.
// - Timer pin low disables termination and timer.
// - Timer pin tied high disables timer only.
// - No supply puts device to sleep.
// - Status pins encode charging, done, else off.
// - Power good on above exit threshold.
// - Enable low allows charging, high inhibits.
// - Enable falling edge clears timers and faults.
// - Timeout above recharge: wait drop, then detect.
// - Timeout below recharge: detect current until rise.
// - Reset or enable toggle clears timeout fault.
// - Overvoltage stops switching until recharge level.
// - Temperature suspend stops switching, freezes timers.
// - Detection tests pass: absent; fail: new cycle.
`timescale 1ns/1ns
`default_nettype none
`include "charge_seq_regs.vh"

module battery_charge_sequencer #(
  parameter [31:0] COND_TIMEOUT_MS = `COND_TIMEOUT_S * 1000,
  parameter [31:0] CHARGE_TIMEOUT_MS = `CHARGE_TIMEOUT_S * 1000,
  parameter [31:0] DISCH_MS = `DISCHARGE_TEST_MS,
  parameter [31:0] WAKE_MS = `WAKE_TEST_MS
) (
  input wire clk,
  input wire rstn,
  input wire supply_present,
  input wire batt_below_low,
  input wire batt_below_recharge,
  input wire batt_below_short,
  input wire current_at_term,
  input wire over_voltage,
  input wire temp_ok,
  input wire charge_enable_n,
  input wire timer_ctrl_low,
  input wire timer_ctrl_high,
  input wire cell_select,
  output reg switch_enable,
  output reg precharge_mode,
  output reg two_cell_target,
  output reg detect_current_on,
  output reg discharge_current_on,
  output reg wake_current_on,
  output reg status_out_a_oe_n,
  output reg status_out_b_oe_n,
  output reg supply_good_n_oe_n
);

  ////////////////////////////////////////////////////////////////////////
  // Input conditioning

  localparam NIN = 12;
  wire [NIN-1:0] raw_in;
  wire [NIN-1:0] f;
  assign raw_in = {cell_select, timer_ctrl_high, timer_ctrl_low,
    charge_enable_n, temp_ok, over_voltage, current_at_term,
    batt_below_short, batt_below_recharge, batt_below_low,
    supply_present, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_filt
      input_filter u_filt (
        .clk(clk),
        .rstn(rstn),
        .raw(raw_in[gi]),
        .init_level(1'b0),
        .level(f[gi])
      );
    end
  endgenerate

  wire supply_ok = f[1];
  wire below_low = f[2];
  wire below_rch = f[3];
  wire below_short = f[4];
  wire at_term = f[5];
  wire ovp = f[6];
  wire temp_good = f[7];
  wire ce_n = f[8];
  wire ttc_low = f[9];
  wire ttc_high = f[10];
  wire cells2 = f[11];

  ////////////////////////////////////////////////////////////////////////
  // Edges and millisecond tick

  reg ce_n_d;
  reg ttc_low_d;
  reg ready;
  reg [`MS_DIV_W-1:0] ms_div;
  reg ms_tick;

  // Filter outputs settle low after reset, so ignore edges until ready
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ce_n_d <= 1'b0;
      ttc_low_d <= 1'b0;
      ready <= 1'b0;
      ms_div <= {`MS_DIV_W{1'b0}};
      ms_tick <= 1'b0;
    end else begin
      ce_n_d <= ce_n;
      ttc_low_d <= ttc_low;
      ready <= 1'b1;
      ms_tick <= 1'b0;
      if (ms_div == `MS_DIV_CYCLES - 1) begin
        ms_div <= {`MS_DIV_W{1'b0}};
        ms_tick <= 1'b1;
      end else begin
        ms_div <= ms_div + 1'b1;
      end
    end
  end

  wire ce_fall = ready && ce_n_d && !ce_n;
  wire ce_rise = ready && !ce_n_d && ce_n;
  wire ttc_rise = ready && ttc_low_d && !ttc_low;
  wire term_on = !ttc_low;
  wire safety_on = !ttc_low && !ttc_high;

  ////////////////////////////////////////////////////////////////////////
  // State machine

  reg [`ST_W-1:0] state;
  reg [`ST_W-1:0] next_state;
  reg flt_low_side;
  reg next_flt_low_side;
  wire cond_exp;
  wire chg_exp;
  wire test_exp;

  function is_charging;
    input [`ST_W-1:0] s;
    begin
      is_charging = (s == `ST_COND) || (s == `ST_FAST);
    end
  endfunction

  // Start of a cycle: conditioning when low, else fast charge
  function [`ST_W-1:0] start_state;
    input low;
    begin
      start_state = low ? `ST_COND : `ST_FAST;
    end
  endfunction

  wire suspend = is_charging(state) && !temp_good;
  wire timers_clear = (state != next_state && !is_charging(next_state))
    || (state == `ST_IDLE) || ce_fall || ttc_rise;
  wire test_clear = state != next_state;

  always @* begin
    next_state = state;
    next_flt_low_side = flt_low_side;
    case (state)
      `ST_IDLE: begin
        if (!supply_ok)
          next_state = `ST_SLEEP;
        else if (!ce_n && ready)
          next_state = start_state(below_low);
      end
      `ST_SLEEP: begin
        if (supply_ok)
          next_state = `ST_IDLE;
      end
      `ST_COND: begin
        if (below_low && cond_exp && safety_on)
          next_state = `ST_PREFAULT;
        else if (!below_low)
          next_state = `ST_FAST;
      end
      `ST_FAST: begin
        if (chg_exp && safety_on) begin
          next_state = `ST_TMOFAULT;
          next_flt_low_side = below_rch;
        end else if (term_on && at_term && !below_rch)
          next_state = `ST_DONE;
      end
      `ST_DONE: begin
        if (below_rch)
          next_state = `ST_DISCH;
      end
      `ST_PREFAULT: begin
        if (!below_low)
          next_state = `ST_IDLE;
      end
      `ST_TMOFAULT: begin
        if (flt_low_side) begin
          if (!below_rch)
            next_flt_low_side = 1'b0;
        end else if (below_rch)
          next_state = `ST_DISCH;
      end
      `ST_OVP: begin
        if (below_rch)
          next_state = `ST_IDLE;
      end
      `ST_DISCH: begin
        if (test_exp)
          next_state = below_short ? `ST_WAKE : `ST_IDLE;
      end
      `ST_WAKE: begin
        if (test_exp)
          next_state = below_rch ? `ST_IDLE : `ST_DONE;
      end
      default: next_state = `ST_IDLE;
    endcase
    // Global overrides, strongest last
    if (state != `ST_SLEEP && state != `ST_OVP && ovp && supply_ok)
      next_state = `ST_OVP;
    if (ce_n && state != `ST_SLEEP)
      next_state = `ST_IDLE;
    if (ce_fall || ce_rise)
      next_state = `ST_IDLE;
    if (ttc_rise && state != `ST_SLEEP)
      next_state = `ST_IDLE;
    if (!supply_ok)
      next_state = `ST_SLEEP;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= `ST_IDLE;
      flt_low_side <= 1'b0;
    end else begin
      state <= next_state;
      flt_low_side <= next_flt_low_side;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers

  seconds_timer u_cond_tmr (
    .clk(clk),
    .rstn(rstn),
    .clear(timers_clear || state != `ST_COND),
    .run(!suspend),
    .tick(ms_tick),
    .limit_ms(COND_TIMEOUT_MS),
    .expired(cond_exp)
  );

  seconds_timer u_chg_tmr (
    .clk(clk),
    .rstn(rstn),
    .clear(timers_clear),
    .run(is_charging(state) && !suspend && safety_on),
    .tick(ms_tick),
    .limit_ms(CHARGE_TIMEOUT_MS),
    .expired(chg_exp)
  );

  seconds_timer u_test_tmr (
    .clk(clk),
    .rstn(rstn),
    .clear(test_clear),
    .run(state == `ST_DISCH || state == `ST_WAKE),
    .tick(ms_tick),
    .limit_ms(state == `ST_WAKE ? WAKE_MS : DISCH_MS),
    .expired(test_exp)
  );

  // Detection passed: rest in done, but both status pins stay off
  reg absent;
  wire next_absent = next_state == `ST_DONE && (absent || state == `ST_WAKE);

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      absent <= 1'b0;
    else
      absent <= next_absent;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs; open-drain enable low means pin pulled low

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      switch_enable <= 1'b0;
      precharge_mode <= 1'b0;
      two_cell_target <= 1'b0;
      detect_current_on <= 1'b0;
      discharge_current_on <= 1'b0;
      wake_current_on <= 1'b0;
      status_out_a_oe_n <= 1'b1;
      status_out_b_oe_n <= 1'b1;
      supply_good_n_oe_n <= 1'b1;
    end else begin
      switch_enable <= is_charging(next_state) && !suspend
        && next_state == state;
      precharge_mode <= next_state == `ST_COND;
      two_cell_target <= cells2;
      detect_current_on <= next_state == `ST_PREFAULT ||
        (next_state == `ST_TMOFAULT && next_flt_low_side);
      discharge_current_on <= next_state == `ST_DISCH;
      wake_current_on <= next_state == `ST_WAKE;
      status_out_a_oe_n <= !(is_charging(next_state) && !suspend);
      status_out_b_oe_n <= !(next_state == `ST_DONE
        && !next_absent);
      supply_good_n_oe_n <= !(supply_ok && next_state != `ST_SLEEP);
    end
  end
endmodule
`default_nettype wire

/* File: design/input_filter.v */
// Three-flop synchroniser and debouncer for one asynchronous input.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ns
`default_nettype none
`include "charge_seq_regs.vh"

module input_filter (
  input wire clk,
  input wire rstn,
  input wire raw,
  input wire init_level,
  output reg level
);
  reg sync_a;
  reg sync_b;
  reg sync_c;
  reg [15:0] count;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Level accepted only after it holds steady for the filter time
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 16'h0000;
      level <= 1'b0;
    end else if (sync_b != sync_c || sync_c == level) begin
      count <= 16'h0000;
    end else if (count == `DEB_CYCLES - 16'h0001) begin
      count <= 16'h0000;
      level <= sync_c;
    end else begin
      count <= count + 16'h0001;
    end
  end
  // init_level unused by design: reset value fixed low for all inputs
  wire unused_init = init_level;
endmodule
`default_nettype wire

/* File: design/seconds_timer.v */
// Millisecond-tick timer with clear, freeze and expiry flag.
// Assumes tick is a one-cycle pulse from the caller's prescaler.
`timescale 1ns/1ns
`default_nettype none

module seconds_timer (
  input wire clk,
  input wire rstn,
  input wire clear,
  input wire run,
  input wire tick,
  input wire [31:0] limit_ms,
  output reg expired
);
  reg [31:0] count;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h00000000;
      expired <= 1'b0;
    end else if (clear) begin
      count <= 32'h00000000;
      expired <= 1'b0;
    end else if (run && tick && !expired) begin
      if (count + 32'h00000001 >= limit_ms)
        expired <= 1'b1;
      count <= count + 32'h00000001;
    end
  end
endmodule
`default_nettype wire

/* File: pkg/charge_seq_regs.vh */
// Constants for the battery charge sequencer: state codes, timing counts.
// Assumes a 10 MHz clk; included by the sequencer and input filter design files.
`ifndef CHARGE_SEQ_REGS_VH
`define CHARGE_SEQ_REGS_VH

`define CLK_HZ 10000000
// Filter length of the input debouncer, in clock cycles
`define DEB_CYCLES 16'h0010
// Conditioning timeout, seconds (default; parameter shortens it)
`define COND_TIMEOUT_S 1800
// Charge safety timeout default, seconds (set by capacitor in reality)
`define CHARGE_TIMEOUT_S 18000
// Detection routine test times, milliseconds
`define DISCHARGE_TEST_MS 1000
`define WAKE_TEST_MS 500
// Prescaler for the one-millisecond tick
`define MS_DIV_CYCLES (`CLK_HZ / 1000)
`define MS_DIV_W 14

// One-hot states
`define ST_W 10
`define ST_IDLE 10'h001
`define ST_SLEEP 10'h002
`define ST_COND 10'h004
`define ST_FAST 10'h008
`define ST_DONE 10'h010
`define ST_PREFAULT 10'h020
`define ST_TMOFAULT 10'h040
`define ST_OVP 10'h080
`define ST_DISCH 10'h100
`define ST_WAKE 10'h200

`endif

/* File: tb/battery_model.sv */
// Battery pack model: turns a cell voltage into comparator levels.
// Assumes the bench sets the voltage and the charger reports switching.
`timescale 1ns/1ns
`default_nettype none
module battery_model #(
  parameter integer RCH_MV = 100,
  parameter integer OVP_MV = 200
) (
  input wire logic two_cell,
  input wire logic charging,
  input wire logic [15:0] batt_mv,
  output logic below_low,
  output logic below_rch,
  output logic below_short,
  output logic at_term,
  output logic ovp
);
  logic [15:0] reg_mv;
  //////////////////////////////
  always_comb begin
    reg_mv = two_cell ? 16'h20D0 : 16'h1068;
    below_low = batt_mv < reg_mv * 3 / 4;
    below_rch = batt_mv < reg_mv - RCH_MV;
    below_short = batt_mv < reg_mv / 2;
    ovp = batt_mv > reg_mv + OVP_MV;
    // Taper only at regulation, never while overvoltage
    at_term = charging && !ovp && batt_mv >= reg_mv - 10;
  end
endmodule
`default_nettype wire

/* File: tb/charge_seq_asserts.sv */
// Checker on the charge sequencer ports.
// Assumes input filters of about 20 clk cycles.
`timescale 1ns/1ns
`default_nettype none
module charge_seq_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_present,
  input wire logic over_voltage,
  input wire logic cell_select,
  input wire logic charge_enable_n,
  input wire logic switch_enable,
  input wire logic precharge_mode,
  input wire logic two_cell_target,
  input wire logic detect_current_on,
  input wire logic status_out_a_oe_n,
  input wire logic status_out_b_oe_n,
  input wire logic supply_good_n_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles without supply; filter delay hides the first ones
  logic [5:0] off_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) off_cnt <= 6'h00;
    else if (supply_present) off_cnt <= 6'h00;
    else if (off_cnt != 6'h3F) off_cnt <= off_cnt + 6'h01;
  end
  //////////////////////////////
  a_sleep_off: assert property (off_cnt > 6'h20 |->
    supply_good_n_oe_n && !switch_enable) else $error("Awake without supply");
  a_status_both: assert property (
    status_out_a_oe_n || status_out_b_oe_n) else $error("Both status on");
  a_switch_status: assert property (switch_enable |->
    !status_out_a_oe_n && status_out_b_oe_n) else $error("Status not charging");
  a_switch_pg: assert property (
    switch_enable |-> !supply_good_n_oe_n) else $error("Switching, pg off");
  a_ovp_stop: assert property ($rose(over_voltage) |-> ##[1:40]
    (!switch_enable && status_out_a_oe_n && status_out_b_oe_n))
    else $error("Overvoltage not handled");
  a_cell_target: assert property ($changed(cell_select) |->
    ##[1:40] two_cell_target == cell_select) else $error("Target wrong");
  a_enable_off: assert property ($rose(charge_enable_n) |->
    ##[1:40] !switch_enable && !precharge_mode) else $error("Not inhibited");
  a_detect_idle: assert property (detect_current_on |->
    !switch_enable && status_out_a_oe_n) else $error("Detect while charging");
  a_done_stop: assert property (
    $fell(status_out_b_oe_n) |-> !switch_enable) else $error("Done, switching");
endmodule
bind battery_charge_sequencer charge_seq_checker charge_seq_checker_inst (
  .clk(clk), .rstn(rstn), .supply_present(supply_present),
  .over_voltage(over_voltage), .cell_select(cell_select),
  .charge_enable_n(charge_enable_n), .switch_enable(switch_enable),
  .precharge_mode(precharge_mode), .two_cell_target(two_cell_target),
  .detect_current_on(detect_current_on),
  .status_out_a_oe_n(status_out_a_oe_n),
  .status_out_b_oe_n(status_out_b_oe_n),
  .supply_good_n_oe_n(supply_good_n_oe_n));
`default_nettype wire

/* File: tb/tb_battery_charge_sequencer.sv */
// Self-checking bench for the charge sequencer with a battery model.
// Assumes shortened timer parameters (ms tick of 10000 clk).
`timescale 1ns/1ns
`default_nettype none
module tb_battery_charge_sequencer;
  typedef struct packed {
    logic [4:0] ctl;
    logic [15:0] mv;
    logic [6:0] exp;
  } row_t;
  row_t rows [16];
  logic clk = 1'b0;
  logic rstn = 1'b0;
  // supply, enable_n, temp, timer pin low, cell select
  logic [4:0] ctl = 5'h14;
  logic [15:0] mv = 16'h09C4;
  logic timer_ctrl_high = 1'b0;
  logic below_low, below_rch, below_short, at_term, ovp;
  logic sw, pre, two, det, a_oe_n, b_oe_n, pg_oe_n;
  logic dc, wk;
  logic [6:0] outs;
  logic [8:0] flags;
  integer bad_count = 0;
  integer comparisons = 0;
  integer i, r;
  assign outs = {sw, pre, two, a_oe_n, b_oe_n, pg_oe_n, det};
  assign flags = {wk, dc, outs};
  // Wake test spans at least one full tick so the bench can react in it
  battery_charge_sequencer #(.COND_TIMEOUT_MS(32'h1),
    .CHARGE_TIMEOUT_MS(32'h2), .DISCH_MS(32'h1), .WAKE_MS(32'h2))
    battery_charge_sequencer_inst (.clk(clk), .rstn(rstn),
    .supply_present(ctl[4]), .batt_below_low(below_low),
    .batt_below_recharge(below_rch), .batt_below_short(below_short),
    .current_at_term(at_term), .over_voltage(ovp), .temp_ok(ctl[2]),
    .charge_enable_n(ctl[3]), .timer_ctrl_low(ctl[1]),
    .timer_ctrl_high(timer_ctrl_high), .cell_select(ctl[0]),
    .switch_enable(sw), .precharge_mode(pre), .two_cell_target(two),
    .detect_current_on(det), .discharge_current_on(dc), .wake_current_on(wk),
    .status_out_a_oe_n(a_oe_n), .status_out_b_oe_n(b_oe_n),
    .supply_good_n_oe_n(pg_oe_n));
  battery_model battery_model_inst (.two_cell(two), .charging(sw),
    .batt_mv(mv), .below_low(below_low), .below_rch(below_rch),
    .below_short(below_short), .at_term(at_term), .ovp(ovp));
  initial begin
    forever #50 clk = ~clk;
  end
  //////////////////////////////
  task check(input logic [6:0] seen, input logic [6:0] want);
    comparisons++;
    if (seen !== want) begin
      $display("Error at %0t: outputs %h, expected %h", $time, seen, want);
      bad_count++;
    end
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Inputs must outlast the 20-cycle filters
  task apply(input logic [4:0] c, input logic [15:0] v);
    @(posedge clk);
    ctl <= c;
    mv <= v;
    repeat (45) @(negedge clk);
  endtask
  task wait_out(input integer b, input logic val);
    for (i = 0; i < 40000 && flags[b] !== val; i++) @(negedge clk);
    if (i == 40000) begin
      $display("Error at %0t: state change missing", $time);
      bad_count++;
      complete_run;
    end
  endtask
  initial begin
    rows = '{'{5'h14, 16'h09C4, 7'h64}, '{5'h14, 16'h0E74, 7'h44},
      '{5'h10, 16'h0E74, 7'h0C}, '{5'h14, 16'h0E74, 7'h44},
      '{5'h14, 16'h1068, 7'h08}, '{5'h1C, 16'h0E74, 7'h0C},
      '{5'h14, 16'h0E74, 7'h44}, '{5'h14, 16'h1194, 7'h0C},
      '{5'h14, 16'h0FA0, 7'h44}, '{5'h04, 16'h0FA0, 7'h0E},
      '{5'h14, 16'h0FA0, 7'h44}, '{5'h1D, 16'h0E74, 7'h1C},
      '{5'h15, 16'h0E74, 7'h74}, '{5'h1E, 16'h1068, 7'h0C},
      '{5'h16, 16'h1068, 7'h44}, '{5'h14, 16'h1068, 7'h08}};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (r = 0; r < 16; r++) begin
      apply(rows[r].ctl, rows[r].mv);
      check(outs, rows[r].exp);
      $display("Row %0d done", r);
    end
    apply(5'h1C, 16'h09C4);
    apply(5'h14, 16'h09C4);
    wait_out(0, 1'b1);
    check(outs, 7'h0D);
    apply(5'h14, 16'h0E74);
    check(outs, 7'h44);
    $display("Conditioning timeout done");
    wait_out(6, 1'b0);
    repeat (3) @(negedge clk);
    check(outs, 7'h0D);
    apply(5'h14, 16'h1068);
    check(outs, 7'h0C);
    // Fault above recharge level: a drop starts the detection routine
    @(posedge clk);
    mv <= 16'h07D0;
    wait_out(7, 1'b1);
    check(outs, 7'h0C);
    wait_out(8, 1'b1);
    check({5'h00, wk, dc}, 7'h02);
    apply(5'h14, 16'h1068);
    wait_out(8, 1'b0);
    check(outs, 7'h0C);
    check({5'h00, wk, dc}, 7'h00);
    $display("Detection routine done");
    apply(5'h1C, 16'h0E74);
    apply(5'h14, 16'h0E74);
    check(outs, 7'h44);
    wait_out(6, 1'b0);
    check(outs, 7'h0D);
    apply(5'h1C, 16'h0E74);
    apply(5'h14, 16'h0E74);
    check(outs, 7'h44);
    $display("Charge timeout done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(negedge clk);
    check(outs, 7'h0E);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (45) @(negedge clk);
    check(outs, 7'h44);
    // Timer pin tied high: termination must still end the charge
    @(posedge clk);
    timer_ctrl_high <= 1'b1;
    apply(5'h14, 16'h1068);
    check(outs, 7'h08);
    $display("Reset test done");
    complete_run;
  end
endmodule
`default_nettype wire
